// *** hw/msc_pkg.sv ***
// constants, types and field layout of the mode/supply and hardware config registers
package msc_pkg;
   // ----------------------------------------------------------------
   // addresses and frame
   // ----------------------------------------------------------------
   localparam int            ADDR_W           = 7;
   localparam int            DATA_W           = 8;
   localparam logic [4:0]    FRAME_BITS       = 5'h10;
   localparam logic [4:0]    ADDR_BITS        = 5'h08;
   localparam logic [6:0]    ADDR_MODE_SUPPLY = 7'h01;
   localparam logic [6:0]    ADDR_HW_CONFIG   = 7'h02;
   // ----------------------------------------------------------------
   // mode/supply fields
   // ----------------------------------------------------------------
   localparam int            MS_MODE_LO       = 6;
   localparam int            MS_AUX_EN        = 5;
   localparam int            MS_POLICY_LO     = 3;
   localparam int            MS_OV_ESC        = 2;
   localparam int            MS_THRESH_LO     = 0;
   localparam logic [7:0]    MS_POR_VALUE     = 8'h00;
   localparam logic [7:0]    MS_RESTART_KEEP  = 8'h23;
   // ----------------------------------------------------------------
   // hardware config fields
   // ----------------------------------------------------------------
   localparam int            HW_AUX_VSEL      = 7;
   localparam int            HW_SR_SUPPRESS   = 6;
   localparam int            HW_FO_FORCE      = 5;
   localparam int            HW_UV_KEEP       = 4;
   localparam int            HW_LOAD_SHARE    = 3;
   localparam int            HW_LS_STOP       = 1;
   localparam int            HW_WD_FIRST      = 0;
   localparam logic [7:0]    HW_POR_VALUE     = 8'h00;
   localparam logic [7:0]    HW_SOFT_KEEP     = 8'h88;
   localparam logic [7:0]    HW_RESTART_KEEP  = 8'hD9;
   localparam logic [7:0]    HW_WRITE_MASK    = 8'hFB;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int            RESET_PIN_CYCLES = 16;
   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MSC_MODE_NORMAL = 2'b00,
      MSC_MODE_SLEEP  = 2'b01,
      MSC_MODE_STOP   = 2'b10,
      MSC_MODE_SOFT   = 2'b11
   } msc_mode_t;
   typedef enum logic [1:0] {
      MSC_POL_OFF    = 2'b00,
      MSC_POL_NORMAL = 2'b01,
      MSC_POL_NSTOP  = 2'b10,
      MSC_POL_ALWAYS = 2'b11
   } msc_policy_t;
   typedef enum logic [1:0] {
      MSC_SPI_IDLE = 2'b00,
      MSC_SPI_ADDR = 2'b01,
      MSC_SPI_DATA = 2'b10
   } msc_spi_state_t;
   typedef struct packed {
      logic [7:0] data;
      logic       write;
      logic [6:0] addr;
   } msc_frame_t;
   typedef struct packed {
      logic       secondaryOn;
      logic       auxOn;
      logic       auxVoltageAlt;
      logic       auxLoadShare;
      logic       auxLoadShareStop;
      logic [1:0] thresholdSel;
   } msc_supply_ctl_t;
endpackage

// *** hw/msc_pin_sync.sv ***
// three-stage synchroniser for pin inputs, change taken when stages two and three agree
`timescale 1ns/1ps
module msc_pin_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             reset,
   // pins and stable result
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] stable
);
   if (WIDTH < 1) begin : g_bad_width
      $error("msc_pin_sync: WIDTH must be at least 1");
   end
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      logic [2:0] stage;
      always_ff @(posedge clk_sys or posedge reset) begin
         if (reset) begin
            stage     <= {3{RESET_VAL[i]}};
            stable[i] <= RESET_VAL[i];
         end else begin
            stage <= {stage[1:0], pinIn[i]};
            // stage[0] feeds only stage[1]
            if (stage[1] == stage[2]) begin
               stable[i] <= stage[2];
            end
         end
      end
   end
endmodule // msc_pin_sync

// *** hw/msc_pulse_stretch.sv ***
// fixed-length pulse generator for the reset output pin
`timescale 1ns/1ps
module msc_pulse_stretch #(
   parameter int CYCLES = 16
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic reset,
   // trigger and stretched level
   input  wire logic trigger,
   output logic      active
);
   localparam int CW = $clog2(CYCLES + 1);
   if (CYCLES < 1) begin : g_bad_cycles
      $error("msc_pulse_stretch: CYCLES must be at least 1");
   end
   logic [CW-1:0] remain;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         remain <= '0;
      end else if (trigger) begin
         remain <= CW'(CYCLES);
      end else if (remain != '0) begin
         remain <= remain - CW'(1);
      end
   end
   assign active = (remain != '0);
endmodule // msc_pulse_stretch

// *** hw/msc_mode_supply_regs.sv ***
// mode/supply and hardware config registers behind the 16-bit serial port
`timescale 1ns/1ps
module msc_mode_supply_regs
   import msc_pkg::*;
#(
   parameter int RESET_PULSE_CYCLES = RESET_PIN_CYCLES
) (
   // clock and reset
   input  wire logic      clk_sys,
   input  wire logic      reset,
   // serial port pins
   input  wire logic      spiCsN,
   input  wire logic      spiClk,
   input  wire logic      spiMosi,
   output logic           spiMiso,
   output logic           spiMisoOe,
   // device events, same clock
   input  wire logic      restartEnter,
   input  wire logic      overtempEvent,
   input  wire logic      mainOvervoltage,
   input  wire logic      mainOvFlagClear,
   input  wire logic      supplyUndervoltage,
   input  wire logic      failSafeActive,
   input  wire logic      failureCondition,
   input  wire logic      failureFlagClear,
   input  wire logic      wdTriggerFail,
   // mode and supply control
   output msc_mode_t      opMode,
   output logic           softResetPulse,
   output msc_supply_ctl_t supplyCtl,
   // status and escalation
   output logic           mainOvFlag,
   output logic           escalateRequest,
   output logic           failureOutputs,
   // reset output pin, open drain
   output logic           resetPinOut,
   output logic           resetPinOe,
   // register views
   output logic [7:0]     modeSupply,
   output logic [7:0]     hwConfig
);
   if (RESET_PULSE_CYCLES < 1) begin : g_bad_pulse
      $error("msc_mode_supply_regs: RESET_PULSE_CYCLES must be at least 1");
   end

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   logic [2:0] pinStable;
   logic       csN;
   logic       sck;
   logic       mosi;
   logic       sckPrev;
   logic       csPrev;

   msc_pin_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'b100)
   ) u_sync (
      .clk_sys (clk_sys),
      .reset   (reset),
      .pinIn   ({spiCsN, spiClk, spiMosi}),
      .stable  (pinStable)
   );

   assign csN  = pinStable[2];
   assign sck  = pinStable[1];
   assign mosi = pinStable[0];

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sckPrev <= 1'b0;
         csPrev  <= 1'b1;
      end else begin
         sckPrev <= sck;
         csPrev  <= csN;
      end
   end

   logic sckRise;
   logic sckFall;
   logic csFall;
   logic csRise;
   assign sckRise = sck & ~sckPrev & ~csN;
   assign sckFall = ~sck & sckPrev & ~csN;
   assign csFall  = ~csN & csPrev;
   assign csRise  = csN & ~csPrev;

   // ----------------------------------------------------------------
   // frame receiver
   // ----------------------------------------------------------------
   msc_spi_state_t spiState;
   msc_spi_state_t next_spiState;
   logic [15:0]    shiftIn;
   logic [15:0]    next_shiftIn;
   logic [4:0]     bitCount;
   logic [7:0]     txByte;
   logic           frameDone;
   msc_frame_t     frame;

   assign next_shiftIn = {mosi, shiftIn[15:1]};
   assign frame        = msc_frame_t'(shiftIn);

   // contents before any update of this frame
   function automatic logic [7:0] readBack(input logic [6:0] a,
                                           input logic [7:0] ms,
                                           input logic [7:0] hw);
      logic [7:0] r;
      r = 8'h00;
      if (a == ADDR_MODE_SUPPLY) begin
         r = ms;
      end else if (a == ADDR_HW_CONFIG) begin
         r = hw & HW_WRITE_MASK;
      end
      return r;
   endfunction

   always_comb begin
      next_spiState = spiState;
      case (spiState)
         MSC_SPI_IDLE: begin
            if (csFall) begin
               next_spiState = MSC_SPI_ADDR;
            end
         end
         MSC_SPI_ADDR: begin
            if (csRise) begin
               next_spiState = MSC_SPI_IDLE;
            end else if (sckRise && bitCount == ADDR_BITS - 5'h01) begin
               next_spiState = MSC_SPI_DATA;
            end
         end
         MSC_SPI_DATA: begin
            if (csRise) begin
               next_spiState = MSC_SPI_IDLE;
            end
         end
         default: next_spiState = MSC_SPI_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         spiState <= MSC_SPI_IDLE;
      end else begin
         spiState <= next_spiState;
      end
   end

   // counter saturates one past a full frame so long frames are dropped
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         bitCount <= 5'h00;
         shiftIn  <= 16'h0000;
      end else if (csFall) begin
         bitCount <= 5'h00;
         shiftIn  <= 16'h0000;
      end else if (sckRise && spiState != MSC_SPI_IDLE) begin
         shiftIn <= next_shiftIn;
         if (bitCount <= FRAME_BITS) begin
            bitCount <= bitCount + 5'h01;
         end
      end
   end

   // answer byte latched once the address is in
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         txByte <= 8'h00;
      end else if (sckRise && spiState == MSC_SPI_ADDR
                   && bitCount == ADDR_BITS - 5'h01) begin
         txByte <= readBack(next_shiftIn[14:8], modeSupply, hwConfig);
      end
   end

   // first answer byte carries no status here and reads zero
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         spiMiso <= 1'b0;
      end else if (csFall) begin
         spiMiso <= 1'b0;
      end else if (sckFall) begin
         if (bitCount >= ADDR_BITS && bitCount < FRAME_BITS) begin
            spiMiso <= txByte[bitCount[2:0]];
         end else begin
            spiMiso <= 1'b0;
         end
      end
   end

   assign spiMisoOe = ~csN;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         frameDone <= 1'b0;
      end else begin
         frameDone <= csRise && spiState == MSC_SPI_DATA
                      && bitCount == FRAME_BITS;
      end
   end

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   logic      writeMs;
   logic      writeHw;
   logic      softReset;
   msc_mode_t wrMode;
   msc_mode_t curMode;

   assign writeMs   = frameDone & frame.write & (frame.addr == ADDR_MODE_SUPPLY);
   assign writeHw   = frameDone & frame.write & (frame.addr == ADDR_HW_CONFIG);
   assign wrMode    = msc_mode_t'(frame.data[MS_MODE_LO +: 2]);
   assign curMode   = msc_mode_t'(modeSupply[MS_MODE_LO +: 2]);
   assign softReset = writeMs & (wrMode == MSC_MODE_SOFT);

   // ----------------------------------------------------------------
   // mode/supply register
   // ----------------------------------------------------------------
   logic [7:0] next_modeSupply;

   always_comb begin
      next_modeSupply = modeSupply;
      if (softReset) begin
         next_modeSupply = MS_POR_VALUE;
      end else if (writeMs) begin
         next_modeSupply = frame.data;
         // a stop-to-sleep request leaves the mode at stop
         if (curMode == MSC_MODE_STOP && wrMode == MSC_MODE_SLEEP) begin
            next_modeSupply[MS_MODE_LO +: 2] = MSC_MODE_STOP;
         end
      end
      if (restartEnter) begin
         // also gives normal mode and secondary policy off
         next_modeSupply = next_modeSupply & MS_RESTART_KEEP;
      end
      if (overtempEvent) begin
         next_modeSupply[MS_POLICY_LO +: 2] = MSC_POL_OFF;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         modeSupply <= MS_POR_VALUE;
      end else begin
         modeSupply <= next_modeSupply;
      end
   end

   // ----------------------------------------------------------------
   // hardware config register
   // ----------------------------------------------------------------
   logic [7:0] next_hwConfig;

   always_comb begin
      next_hwConfig = hwConfig;
      if (softReset) begin
         next_hwConfig = hwConfig & HW_SOFT_KEEP;
      end else if (writeHw) begin
         next_hwConfig = frame.data & HW_WRITE_MASK;
      end
      if (restartEnter) begin
         next_hwConfig = next_hwConfig & HW_RESTART_KEEP;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         hwConfig <= HW_POR_VALUE;
      end else begin
         hwConfig <= next_hwConfig;
      end
   end

   // ----------------------------------------------------------------
   // soft reset and reset pin
   // ----------------------------------------------------------------
   logic pinTrigger;
   logic pinActive;

   // suppress bit sampled before the soft reset clears it
   assign pinTrigger = softReset & ~hwConfig[HW_SR_SUPPRESS];

   msc_pulse_stretch #(
      .CYCLES (RESET_PULSE_CYCLES)
   ) u_pin_pulse (
      .clk_sys (clk_sys),
      .reset   (reset),
      .trigger (pinTrigger),
      .active  (pinActive)
   );

   assign resetPinOut = 1'b0;
   assign resetPinOe  = pinActive;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         softResetPulse <= 1'b0;
      end else begin
         softResetPulse <= softReset;
      end
   end

   assign opMode = curMode;

   // ----------------------------------------------------------------
   // overvoltage and watchdog escalation
   // ----------------------------------------------------------------
   logic [1:0] wdFailCount;
   logic       wdEscalate;

   // set wins over a clear in the same cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mainOvFlag <= 1'b0;
      end else if (mainOvervoltage) begin
         mainOvFlag <= 1'b1;
      end else if (mainOvFlagClear) begin
         mainOvFlag <= 1'b0;
      end
   end

   assign wdEscalate = wdTriggerFail
                       & (hwConfig[HW_WD_FIRST] ? (wdFailCount == 2'd0)
                                                : (wdFailCount == 2'd1));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         wdFailCount <= 2'd0;
      end else if (restartEnter || softReset) begin
         wdFailCount <= 2'd0;
      end else if (wdTriggerFail && wdFailCount != 2'd3) begin
         wdFailCount <= wdFailCount + 2'd1;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         escalateRequest <= 1'b0;
      end else begin
         escalateRequest <= (mainOvervoltage & modeSupply[MS_OV_ESC])
                            | wdEscalate;
      end
   end

   // ----------------------------------------------------------------
   // failure outputs
   // ----------------------------------------------------------------
   logic failureLatched;

   // only the failure flag clear releases a fault-driven activation
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         failureLatched <= 1'b0;
      end else if (failureCondition) begin
         failureLatched <= 1'b1;
      end else if (failureFlagClear) begin
         failureLatched <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         failureOutputs <= 1'b0;
      end else begin
         failureOutputs <= hwConfig[HW_FO_FORCE] | failureLatched;
      end
   end

   // ----------------------------------------------------------------
   // regulator controls
   // ----------------------------------------------------------------
   msc_policy_t     policy;
   msc_supply_ctl_t next_supplyCtl;

   assign policy = msc_policy_t'(modeSupply[MS_POLICY_LO +: 2]);

   always_comb begin
      next_supplyCtl = '0;
      case (policy)
         MSC_POL_OFF:    next_supplyCtl.secondaryOn = 1'b0;
         MSC_POL_NORMAL: next_supplyCtl.secondaryOn = (curMode == MSC_MODE_NORMAL);
         MSC_POL_NSTOP:  next_supplyCtl.secondaryOn = (curMode == MSC_MODE_NORMAL)
                                                      | (curMode == MSC_MODE_STOP);
         MSC_POL_ALWAYS: next_supplyCtl.secondaryOn = ~failSafeActive;
         default:        next_supplyCtl.secondaryOn = 1'b0;
      endcase
      next_supplyCtl.auxOn = modeSupply[MS_AUX_EN]
                             & (~supplyUndervoltage | hwConfig[HW_UV_KEEP]);
      next_supplyCtl.auxVoltageAlt    = hwConfig[HW_AUX_VSEL];
      next_supplyCtl.auxLoadShare     = hwConfig[HW_LOAD_SHARE];
      next_supplyCtl.auxLoadShareStop = hwConfig[HW_LOAD_SHARE]
                                        & hwConfig[HW_LS_STOP];
      next_supplyCtl.thresholdSel     = modeSupply[MS_THRESH_LO +: 2];
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         supplyCtl <= '0;
      end else begin
         supplyCtl <= next_supplyCtl;
      end
   end
endmodule // msc_mode_supply_regs

// *** dv/msc_regs_props.sv ***
// concurrent checks on the mode/supply and hardware config register ports
`timescale 1ns/1ps
module msc_regs_props
   import msc_pkg::*;
#(
   parameter int RESET_PULSE_CYCLES = 16
) (
   // clock and reset
   input wire logic            clk_sys,
   input wire logic            reset,
   // device events
   input wire logic            restartEnter,
   input wire logic            overtempEvent,
   input wire logic            mainOvervoltage,
   // outputs watched
   input wire msc_mode_t       opMode,
   input wire msc_supply_ctl_t supplyCtl,
   input wire logic            mainOvFlag,
   input wire logic            escalateRequest,
   input wire logic            failureOutputs,
   input wire logic            resetPinOe,
   input wire logic [7:0]      modeSupply,
   input wire logic [7:0]      hwConfig
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   logic [7:0] oeRun;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         oeRun <= 8'h00;
      end else begin
         oeRun <= resetPinOe ? oeRun + 8'h01 : 8'h00;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_ov_hit;
      mainOvervoltage && modeSupply[MS_OV_ESC];
   endsequence
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_mode_view: assert property (opMode == modeSupply[7:6])
      else $error("mode output differs from mode field");
   a_restart_mode: assert property (restartEnter |=> modeSupply == ($past(modeSupply) & 8'h23))
      else $error("restart left wrong mode/supply value");
   a_restart_hw: assert property (restartEnter |=> hwConfig == ($past(hwConfig) & 8'hD9))
      else $error("restart left wrong hardware config value");
   a_overtemp_off: assert property (overtempEvent |=> modeSupply[4:3] == 2'b00)
      else $error("secondary policy not off after overtemperature");
   a_ov_flag: assert property (mainOvervoltage |=> mainOvFlag)
      else $error("overvoltage flag not set");
   a_ov_escalate: assert property (s_ov_hit |=> escalateRequest)
      else $error("overvoltage escalation missing");
   a_reserved_zero: assert property (hwConfig[2] == 1'b0)
      else $error("reserved config bit not zero");
   a_supply_follow: assert property (supplyCtl.thresholdSel == $past(modeSupply[1:0])
      && supplyCtl.auxLoadShareStop == $past(hwConfig[3] & hwConfig[1]))
      else $error("supply controls do not follow registers");
   a_force_out: assert property (hwConfig[HW_FO_FORCE] |=> failureOutputs)
      else $error("forced failure outputs not active");
   a_pin_length: assert property ($fell(resetPinOe) |-> oeRun == 8'(RESET_PULSE_CYCLES))
      else $error("reset pin pulse has wrong length");
endmodule // msc_regs_props

bind msc_mode_supply_regs msc_regs_props #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) u_props (
   .clk_sys(clk_sys), .reset(reset), .restartEnter(restartEnter),
   .overtempEvent(overtempEvent), .mainOvervoltage(mainOvervoltage), .opMode(opMode),
   .supplyCtl(supplyCtl), .mainOvFlag(mainOvFlag), .escalateRequest(escalateRequest),
   .failureOutputs(failureOutputs), .resetPinOe(resetPinOe), .modeSupply(modeSupply),
   .hwConfig(hwConfig)
);

// *** dv/msc_spi_host.sv ***
// host-side serial master that frames 16-bit commands
`timescale 1ns/1ps
module msc_spi_host (
   // clock
   input  wire logic  clk_sys,
   // serial pins
   output logic       spiCsN,
   output logic       spiClk,
   output logic       spiMosi,
   input  wire logic  spiMiso,
   // answer byte of the last frame
   output logic [7:0] rdData
);
   event got;
   int   half = 8;
   initial begin
      spiCsN  = 1'b1;
      spiClk  = 1'b0;
      spiMosi = 1'b0;
      rdData  = 8'h00;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // clock stands low between frames; half sets a prompt or slow pace
   task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d);
      logic [15:0] f;
      f = {d, w, a};
      tick(1);
      spiCsN = 1'b0;
      for (int i = 0; i < 16; i++) begin
         spiMosi = f[i];
         tick(half);
         if (i >= 8) rdData[i-8] = spiMiso;
         spiClk = 1'b1;
         tick(half);
         spiClk = 1'b0;
      end
      tick(half);
      spiCsN    = 1'b1;
      spiMosi   = ~spiMosi;
      tick(16);
      -> got;
   endtask
endmodule // msc_spi_host

// *** dv/tb_mode_supply_hw_config_regs.sv ***
// self-checking bench for the mode/supply and hardware config registers
`timescale 1ns/1ps
module tb_mode_supply_hw_config_regs;
   import msc_pkg::*;
   logic        clk_sys = 1'b0, reset = 1'b1;
   logic        restartEnter = 1'b0, overtempEvent = 1'b0, mainOvervoltage = 1'b0;
   logic        mainOvFlagClear = 1'b0, failureCondition = 1'b0, failureFlagClear = 1'b0;
   logic        wdTriggerFail = 1'b0, supplyUndervoltage = 1'b0, failSafeActive = 1'b0;
   wire         spiCsN, spiClk, spiMosi, spiMiso;
   logic [7:0]  rdData, ms = 8'h00, hw = 8'h00, exp[$];
   msc_mode_t   opMode;
   msc_supply_ctl_t supplyCtl;
   logic        mainOvFlag, escalateRequest, failureOutputs, resetPinOe;
   int          fails = 0, samples_checked = 0, escCnt = 0, oeCnt = 0, e, o;
   integer      seed = 32'hC8F02A76;
   always #2.5 clk_sys = ~clk_sys;
   msc_mode_supply_regs #(.RESET_PULSE_CYCLES(4)) uut (
      .clk_sys(clk_sys), .reset(reset), .spiCsN(spiCsN), .spiClk(spiClk),
      .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(), .restartEnter(restartEnter),
      .overtempEvent(overtempEvent), .mainOvervoltage(mainOvervoltage),
      .mainOvFlagClear(mainOvFlagClear), .supplyUndervoltage(supplyUndervoltage),
      .failSafeActive(failSafeActive), .failureCondition(failureCondition),
      .failureFlagClear(failureFlagClear), .wdTriggerFail(wdTriggerFail), .opMode(opMode),
      .softResetPulse(), .supplyCtl(supplyCtl),
      .mainOvFlag(mainOvFlag), .escalateRequest(escalateRequest),
      .failureOutputs(failureOutputs), .resetPinOut(), .resetPinOe(resetPinOe),
      .modeSupply(), .hwConfig()
   );
   msc_spi_host host (
      .clk_sys(clk_sys), .spiCsN(spiCsN), .spiClk(spiClk), .spiMosi(spiMosi),
      .spiMiso(spiMiso), .rdData(rdData)
   );
   always @(posedge clk_sys) begin
      escCnt += escalateRequest;
      oeCnt  += resetPinOe;
   end
   task automatic chk(input string nm, input logic [7:0] ev, input logic [7:0] got);
      samples_checked++;
      if (got !== ev) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, ev, got);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      host.tick(1);
      s = 1'b0;
      host.tick(3);
   endtask
   function automatic logic [7:0] held(input logic [6:0] a);
      return a == ADDR_MODE_SUPPLY ? ms : a == ADDR_HW_CONFIG ? hw : 8'h00;
   endfunction
   task automatic rd(input logic [6:0] a);
      exp.push_back(held(a));
      host.xfer(a, 1'b0, 8'h00);
   endtask
   // the answer of a write is the content before it
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      exp.push_back(held(a));
      host.xfer(a, 1'b1, d);
      if (a == ADDR_HW_CONFIG) hw = d & 8'hFB;
      else if (a == ADDR_MODE_SUPPLY && d[7:6] == 2'b11) begin
         ms = 8'h00;
         hw = hw & 8'h88;
      end else if (a == ADDR_MODE_SUPPLY && d[7:6] == 2'b01 && ms[7:6] == 2'b10)
         ms = {2'b10, d[5:0]};
      else if (a == ADDR_MODE_SUPPLY) ms = d;
   endtask
   task automatic restart;
      pulse(restartEnter);
      ms = ms & 8'h23;
      hw = hw & 8'hD9;
   endtask
   task automatic summarize;
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial forever begin
      @(host.got);
      chk("serial answer", exp.pop_front(), rdData);
   end
   initial begin
      #400us;
      fails++;
      summarize();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      #1 reset = 1'b0;
      host.tick(8);
      rd(ADDR_MODE_SUPPLY);
      rd(ADDR_HW_CONFIG);
      rd(7'h05);
      for (int m = 0; m < 3; m++) begin
         wr(ADDR_MODE_SUPPLY, {2'(m), 6'($random(seed))});
         chk("mode", 8'(m), 8'(opMode));
      end
      wr(ADDR_MODE_SUPPLY, 8'h5B);
      host.half = 12;
      wr(ADDR_HW_CONFIG, 8'($random(seed)) | 8'h04);
      host.half = 8;
      rd(ADDR_HW_CONFIG);
      for (int s = 0; s < 2; s++) begin
         wr(ADDR_HW_CONFIG, {1'b1, s[0], 6'h09});
         o = oeCnt;
         wr(ADDR_MODE_SUPPLY, 8'hC0);
         chk("reset pin cycles", s == 0 ? 8'h04 : 8'h00, 8'(oeCnt - o));
         rd(ADDR_HW_CONFIG);
      end
      wr(ADDR_MODE_SUPPLY, 8'hBF);
      wr(ADDR_HW_CONFIG, 8'hFF);
      restart();
      rd(ADDR_MODE_SUPPLY);
      rd(ADDR_HW_CONFIG);
      wr(ADDR_MODE_SUPPLY, 8'h18);
      pulse(overtempEvent);
      ms[4:3] = 2'b00;
      rd(ADDR_MODE_SUPPLY);
      for (int k = 0; k < 2; k++) begin
         wr(ADDR_MODE_SUPPLY, 8'(4 - 4 * k));
         pulse(mainOvFlagClear);
         e = escCnt;
         pulse(mainOvervoltage);
         chk("overvoltage flag", 8'h01, 8'(mainOvFlag));
         chk("overvoltage escalation", 8'(1 - k), 8'(escCnt - e));
      end
      for (int c = 0; c < 2; c++) begin
         wr(ADDR_HW_CONFIG, 8'(c));
         restart();
         e = escCnt;
         pulse(wdTriggerFail);
         chk("first watchdog fail", 8'(c), 8'(escCnt - e));
         if (c == 0) pulse(wdTriggerFail);
         chk("watchdog escalation", 8'h01, 8'(escCnt - e));
      end
      wr(ADDR_HW_CONFIG, 8'h20);
      chk("forced failure outputs", 8'h01, 8'(failureOutputs));
      pulse(failureCondition);
      wr(ADDR_HW_CONFIG, 8'h00);
      chk("latched failure outputs", 8'h01, 8'(failureOutputs));
      pulse(failureFlagClear);
      chk("released failure outputs", 8'h00, 8'(failureOutputs));
      // policy always-on and aux enabled, then fail-safe and undervoltage
      wr(ADDR_MODE_SUPPLY, 8'h38);
      {failSafeActive, supplyUndervoltage} = 2'b11;
      for (int u = 0; u < 2; u++) begin
         wr(ADDR_HW_CONFIG, 8'(u * 16));
         chk("secondary and aux on", 8'(u), 8'({supplyCtl.secondaryOn, supplyCtl.auxOn}));
      end
      summarize();
   end
endmodule // tb_mode_supply_hw_config_regs
